// *** verilog/hspc_defines.vh ***
// Purpose: shared constants of the hot-swap supervision logic
// Assumes: 50 MHz clk
// Notes:   offsets are management-bus command codes
`ifndef HSPC_DEFINES_VH
`define HSPC_DEFINES_VH
// Command codes
`define HSPC_CMD_OPER     8'h03
`define HSPC_CMD_CLEAR    8'h04
`define HSPC_CMD_OT_FAULT 8'h4F
`define HSPC_CMD_OT_WARN  8'h51
`define HSPC_CMD_VSTAT    8'h80
`define HSPC_CMD_TEMP     8'h8D
`define HSPC_CMD_MASK     8'hD8
`define HSPC_CMD_SETUP    8'hD9
`define HSPC_CMD_DIAG     8'hE1
// Reset values
`define HSPC_OPER_RST     8'h80
`define HSPC_OPER_OFF     8'h00
`define HSPC_OT_FAULT_RST 16'h0096
`define HSPC_OT_WARN_RST  16'h007D
`define HSPC_MASK_RST     16'h0000
`define HSPC_SETUP_RST    8'h00
`define HSPC_ADDR_BASE    7'h40
// Field positions
`define HSPC_OPER_ON      7
`define HSPC_VSTAT_SHORT  7
`define HSPC_DG_SHORT     0
`define HSPC_DG_LATCH     1
`define HSPC_DG_OTW       2
`define HSPC_DG_OTF       3
`define HSPC_DG_UV        4
`define HSPC_DG_OV        5
`define HSPC_DG_GATE      6
// Timing
`define HSPC_CLK_MHZ      50
`define HSPC_TEMP_US      1000
`define HSPC_TEMP_CYC     (`HSPC_TEMP_US * `HSPC_CLK_MHZ)
`define HSPC_PULSE_CYC    16'd50
`define HSPC_RESTART_CYC  16'd1000
`endif

// *** verilog/hspc_temp.v ***
// Purpose: diode drive sequencer and sample capture
// Assumes: converter result temp_adc is on clk
// Notes:   one high-current step per period
`timescale 1ns/100ps
`include "hspc_defines.vh"
module hspc_temp #(
  parameter PERIOD_CYC = `HSPC_TEMP_CYC
) (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Converter side
  input  wire [15:0] temp_adc,
  output reg         diode_hi_q,
  // Result
  output reg  [15:0] temp_q,
  output reg         done_q
);
  reg [31:0] cnt_q;

  // Period counter; pulse steps up drive, its end captures a sample
  always @(posedge clk) begin
    if (srst) begin
      cnt_q      <= 32'h0;
      diode_hi_q <= 1'b0;
      temp_q     <= 16'h0000;
      done_q     <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (cnt_q == PERIOD_CYC - 1) begin
        cnt_q      <= 32'h0;
        diode_hi_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
      if (diode_hi_q && cnt_q == {16'h0, `HSPC_PULSE_CYC}) begin
        diode_hi_q <= 1'b0;
        temp_q     <= temp_adc;
        done_q     <= 1'b1;
      end
    end
  end
endmodule

// *** verilog/hspc_smbus.v ***
// Purpose: management-bus target, byte/word write and read
// Assumes: scl and sda sampled through two flip-flops
// Notes:   first data byte is low byte; sda_oe_n low drives low
`timescale 1ns/100ps
module hspc_smbus (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Pins
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_oe_n,
  // Address
  input  wire [6:0]  addr,
  input  wire        addr_ok,
  // Register side
  output reg  [7:0]  cmd_q,
  output reg         wr_stb_q,
  output reg         wr_hi_q,
  output reg  [7:0]  wr_byte_q,
  input  wire [15:0] rd_word
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_WR   = 3'd3;
  localparam ST_WACK = 3'd4;
  localparam ST_RD   = 3'd5;
  localparam ST_RACK = 3'd6;
  reg [2:0] st_q;
  reg [2:0] bit_q;
  reg [1:0] nbyte_q;
  reg [7:0] sh_q;
  reg       rd_q;
  reg       ack_q;
  reg       scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p;
  wire      scl_rise = scl_s2 & ~scl_p;
  wire      scl_fall = ~scl_s2 & scl_p;
  wire      start    = scl_s2 & scl_p & sda_p & ~sda_s2;
  wire      stop     = scl_s2 & scl_p & ~sda_p & sda_s2;
  wire [7:0] inb     = {sh_q[6:0], sda_s2};
  wire [7:0] rdb     = nbyte_q[0] ? rd_word[15:8] : rd_word[7:0];

  // Pin synchronisers
  always @(posedge clk) begin
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    scl_p  <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_p  <= sda_s2;
  end

  // Bit-level state machine
  always @(posedge clk) begin
    if (srst) begin
      st_q <= ST_IDLE; bit_q <= 3'd0; nbyte_q <= 2'd0; sh_q <= 8'h00;
      rd_q <= 1'b0; ack_q <= 1'b0; sda_oe_n <= 1'b1; cmd_q <= 8'h00;
      wr_stb_q <= 1'b0; wr_hi_q <= 1'b0; wr_byte_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (stop) begin
        st_q <= ST_IDLE; sda_oe_n <= 1'b1;
      end else if (start) begin
        st_q <= ST_ADDR; bit_q <= 3'd0; nbyte_q <= 2'd0; sda_oe_n <= 1'b1;
      end else begin
        case (st_q)
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              sh_q  <= inb;
              bit_q <= bit_q + 3'd1;
              if (bit_q == 3'd7 && st_q == ST_ADDR) begin
                rd_q  <= sda_s2;
                ack_q <= 1'b0;
                st_q  <= (addr_ok && inb[7:1] == addr) ? ST_AACK : ST_IDLE;
              end else if (bit_q == 3'd7) begin
                ack_q <= 1'b0;
                st_q  <= ST_WACK;
                if (nbyte_q == 2'd0) begin
                  cmd_q <= inb;
                end else begin
                  wr_stb_q  <= 1'b1;
                  wr_hi_q   <= nbyte_q[1];
                  wr_byte_q <= inb;
                end
                if (nbyte_q != 2'd3) nbyte_q <= nbyte_q + 2'd1;
              end
            end
          end
          ST_AACK, ST_WACK: begin
            if (scl_fall && !ack_q) begin
              sda_oe_n <= 1'b0;
              ack_q    <= 1'b1;
            end else if (scl_fall) begin
              bit_q <= 3'd0;
              if (st_q == ST_AACK && rd_q) begin
                st_q     <= ST_RD;
                sda_oe_n <= rdb[7];
                sh_q     <= {rdb[6:0], 1'b0};
              end else begin
                st_q     <= ST_WR;
                sda_oe_n <= 1'b1;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              sda_oe_n <= sh_q[7];
              sh_q     <= {sh_q[6:0], 1'b0};
            end else if (scl_rise) begin
              bit_q <= bit_q + 3'd1;
              if (bit_q == 3'd7) st_q <= ST_RACK;
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
            end else if (scl_rise && sda_s2) begin
              st_q <= ST_IDLE;
            end else if (scl_rise) begin
              nbyte_q <= nbyte_q + 2'd1;
              sh_q    <= nbyte_q[0] ? 8'hFF : rd_word[15:8];
              bit_q   <= 3'd0;
              st_q    <= ST_RD;
            end
          end
          default: sda_oe_n <= 1'b1;
        endcase
      end
    end
  end
endmodule

// *** verilog/hspc_top.v ***
// Purpose: supervision and control logic of a hot-swap protector
// Assumes: analog comparators deliver levels; converter on clk
// Notes:   gate_on_q drives the analog gate driver enable
// Overview of operation
// - Once per millisecond step diode current high, otherwise keep low bias.
// - Default limits raise alert when temperature exceeds 125 degrees.
// - Default limits turn pass switch off above 150 degrees.
// - Host rewrites warning (51h) and shutdown (4Fh) limits; compares use them.
// - Temperature read command 8Dh returns latest measurement.
// - Sense above 4mV with gate low sets shorted flag in 80h and E1h.
// - Shorted flag pulls alert low unless masked in D8h.
// - Enable pin low or overvoltage pin high forces gate off.
// - Toggling enable pin clears latched-off state after retries exhausted.
// - Enable and overvoltage pins never alter address or settings.
// - Latch address from three-level pins once supply exceeds 2.6V.
// - Reference pin low postpones address capture and resets all registers.
// - After reference release, latch address once reference exceeds 2.4V.
// - Operation register 03h: 80h enables output, 0h disables it.
// - Retry count 0,1,2,4,8,16 or unlimited chosen in setup register.
// - Latched-off bit in diagnostic_summary stays high while latched.
`timescale 1ns/100ps
`include "hspc_defines.vh"
module hspc_top #(
  parameter TEMP_CYC = `HSPC_TEMP_CYC
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Management bus pins
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output wire        sda_oe_n,
  output reg         smba_out,
  output reg         smba_oe_n,
  // Reference and supply comparators
  input  wire        vref_low_n,
  input  wire        vref_above,
  input  wire        supply_above,
  // Address select pins, 00 ground 01 open 10 high
  input  wire [1:0]  address_select_0,
  input  wire [1:0]  address_select_1,
  input  wire [1:0]  address_select_2,
  // Protection comparators
  input  wire        enable_undervolt_pin,
  input  wire        overvolt_pin,
  input  wire        sense_over_4mv,
  input  wire        gate_is_low,
  input  wire        fault_timeout,
  // Temperature
  input  wire [15:0] temp_adc,
  output wire        diode_hi_q,
  // Gate control
  output reg         gate_on_q
);
  // Tri-level pin value
  function [6:0] tri_val;
    input [1:0] p;
    begin
      tri_val = (p == 2'b10) ? 7'd2 : (p == 2'b01) ? 7'd1 : 7'd0;
    end
  endfunction

  // Retry limit from setup code; 5'h1F means unlimited
  function [4:0] retry_lim;
    input [2:0] c;
    begin
      case (c)
        3'd0: retry_lim = 5'd0;
        3'd1: retry_lim = 5'd1;
        3'd2: retry_lim = 5'd2;
        3'd3: retry_lim = 5'd4;
        3'd4: retry_lim = 5'd8;
        3'd5: retry_lim = 5'd16;
        default: retry_lim = 5'h1F;
      endcase
    end
  endfunction

  // Synchronised pin levels
  reg [1:0]  ref_s, rab_s, sup_s, en_s, ov_s, sns_s, gl_s, ft_s;
  reg [5:0]  adr_s1, adr_s2;
  reg        ft_p, en_p;
  wire       srst = ~rst_n | ~ref_s[1];
  // Registers
  reg [7:0]  oper_q;
  reg [15:0] otf_lim_q, otw_lim_q, mask_q, lo_q;
  reg [7:0]  setup_q;
  reg [6:0]  addr_q;
  reg        addr_ok_q;
  reg        short_q, otw_q, otf_q, latch_q, uv_q, ov_q;
  reg [4:0]  retries_q;
  reg [15:0] rwait_q;
  reg        rwait_on_q;
  reg [15:0] rd_word;
  wire [7:0] cmd;
  wire       wr_stb, wr_hi;
  wire [7:0] wr_byte;
  wire [15:0] temp;
  wire       done;
  wire [7:0] vstat = {short_q, 7'h00};
  wire [15:0] diag = {9'h000, gate_on_q, ov_q, uv_q, otf_q, otw_q, latch_q, short_q};
  wire       clr = wr_stb & ~wr_hi & (cmd == `HSPC_CMD_CLEAR);
  wire       ft_ev = ft_s[1] & ~ft_p;

  // Two-stage synchronisers on every comparator and address pin
  always @(posedge clk) begin
    if (!rst_n) begin
      ref_s <= 2'b00; rab_s <= 2'b00; sup_s <= 2'b00; en_s <= 2'b00;
      ov_s <= 2'b00; sns_s <= 2'b00; gl_s <= 2'b00; ft_s <= 2'b00;
      adr_s1 <= 6'h00; adr_s2 <= 6'h00;
    end else begin
      ref_s <= {ref_s[0], vref_low_n};
      rab_s <= {rab_s[0], vref_above};
      sup_s <= {sup_s[0], supply_above};
      en_s  <= {en_s[0], enable_undervolt_pin};
      ov_s  <= {ov_s[0], overvolt_pin};
      sns_s <= {sns_s[0], sense_over_4mv};
      gl_s  <= {gl_s[0], gate_is_low};
      ft_s  <= {ft_s[0], fault_timeout};
      adr_s1 <= {address_select_2, address_select_1, address_select_0};
      adr_s2 <= adr_s1;
    end
  end

  // Address capture, held off while the reference pin is low
  always @(posedge clk) begin
    if (srst) begin
      addr_q    <= 7'h00;
      addr_ok_q <= 1'b0;
    end else if (!addr_ok_q && sup_s[1] && rab_s[1]) begin
      addr_q    <= `HSPC_ADDR_BASE + 7'd9 * tri_val(adr_s2[5:4])
                   + 7'd3 * tri_val(adr_s2[3:2]) + tri_val(adr_s2[1:0]);
      addr_ok_q <= 1'b1;
    end
  end

  // Register writes; only the reset path and bus writes touch settings
  always @(posedge clk) begin
    if (srst) begin
      oper_q    <= `HSPC_OPER_RST;
      otf_lim_q <= `HSPC_OT_FAULT_RST;
      otw_lim_q <= `HSPC_OT_WARN_RST;
      mask_q    <= `HSPC_MASK_RST;
      setup_q   <= `HSPC_SETUP_RST;
      lo_q      <= 16'h0000;
    end else if (wr_stb && !wr_hi) begin
      lo_q <= {8'h00, wr_byte};
      if (cmd == `HSPC_CMD_OPER) oper_q <= wr_byte;
      if (cmd == `HSPC_CMD_SETUP) setup_q <= wr_byte;
    end else if (wr_stb) begin
      if (cmd == `HSPC_CMD_OT_FAULT) otf_lim_q <= {wr_byte, lo_q[7:0]};
      if (cmd == `HSPC_CMD_OT_WARN) otw_lim_q <= {wr_byte, lo_q[7:0]};
      if (cmd == `HSPC_CMD_MASK) mask_q <= {wr_byte, lo_q[7:0]};
    end
  end

  // Read data selected by the current command
  always @* begin
    if (cmd == `HSPC_CMD_OPER) rd_word = {8'h00, oper_q};
    else if (cmd == `HSPC_CMD_OT_FAULT) rd_word = otf_lim_q;
    else if (cmd == `HSPC_CMD_OT_WARN) rd_word = otw_lim_q;
    else if (cmd == `HSPC_CMD_VSTAT) rd_word = {8'h00, vstat};
    else if (cmd == `HSPC_CMD_TEMP) rd_word = temp;
    else if (cmd == `HSPC_CMD_MASK) rd_word = mask_q;
    else if (cmd == `HSPC_CMD_SETUP) rd_word = {8'h00, setup_q};
    else if (cmd == `HSPC_CMD_DIAG) rd_word = diag;
    else rd_word = 16'h0000;
  end

  // Sticky event flags; a new event wins over a clear
  always @(posedge clk) begin
    if (srst) begin
      short_q <= 1'b0; otw_q <= 1'b0; otf_q <= 1'b0;
      uv_q <= 1'b0; ov_q <= 1'b0;
    end else begin
      if (sns_s[1] && (gl_s[1] || !gate_on_q)) short_q <= 1'b1;
      else if (clr) short_q <= 1'b0;
      if (done && temp > otw_lim_q) otw_q <= 1'b1;
      else if (clr) otw_q <= 1'b0;
      if (done && temp > otf_lim_q) otf_q <= 1'b1;
      else if (clr) otf_q <= 1'b0;
      if (!en_s[1]) uv_q <= 1'b1;
      else if (clr) uv_q <= 1'b0;
      if (ov_s[1]) ov_q <= 1'b1;
      else if (clr) ov_q <= 1'b0;
    end
  end

  // Retry counting, restart wait and latched-off state
  always @(posedge clk) begin
    if (srst) begin
      ft_p <= 1'b0; en_p <= 1'b0; latch_q <= 1'b0;
      retries_q <= 5'd0; rwait_q <= 16'h0000; rwait_on_q <= 1'b0;
    end else begin
      ft_p <= ft_s[1];
      en_p <= en_s[1];
      if (rwait_on_q) begin
        if (rwait_q == `HSPC_RESTART_CYC - 16'd1) rwait_on_q <= 1'b0;
        rwait_q <= rwait_q + 16'd1;
      end
      if (ft_ev) begin
        if (retry_lim(setup_q[2:0]) == 5'h1F
            || retries_q < retry_lim(setup_q[2:0])) begin
          if (retries_q != 5'h1E) retries_q <= retries_q + 5'd1;
          rwait_on_q <= 1'b1;
          rwait_q    <= 16'h0000;
        end else begin
          latch_q <= 1'b1;
        end
      end else if (!en_s[1] && en_p) begin
        latch_q   <= 1'b0;
        retries_q <= 5'd0;
      end else if (wr_stb && !wr_hi && cmd == `HSPC_CMD_OPER
                   && wr_byte == `HSPC_OPER_OFF) begin
        latch_q   <= 1'b0;
        retries_q <= 5'd0;
      end
    end
  end

  // Gate drive and alert outputs
  always @(posedge clk) begin
    if (srst) begin
      gate_on_q <= 1'b0;
      sda_out   <= 1'b0;
      smba_out  <= 1'b0;
      smba_oe_n <= 1'b1;
    end else begin
      gate_on_q <= oper_q[`HSPC_OPER_ON] & en_s[1] & ~ov_s[1]
                   & ~latch_q & ~otf_q & ~rwait_on_q & ~ft_s[1];
      sda_out   <= 1'b0;
      smba_out  <= 1'b0;
      smba_oe_n <= ~|(diag[3:0] & ~mask_q[3:0] & 4'hD);
    end
  end

  // Temperature sampling
  hspc_temp #(
    .PERIOD_CYC (TEMP_CYC)
  ) u_temp (
    .clk        (clk),
    .srst       (srst),
    .temp_adc   (temp_adc),
    .diode_hi_q (diode_hi_q),
    .temp_q     (temp),
    .done_q     (done)
  );

  // Management bus target
  hspc_smbus u_bus (
    .clk       (clk),
    .srst      (srst),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_oe_n  (sda_oe_n),
    .addr      (addr_q),
    .addr_ok   (addr_ok_q),
    .cmd_q     (cmd),
    .wr_stb_q  (wr_stb),
    .wr_hi_q   (wr_hi),
    .wr_byte_q (wr_byte),
    .rd_word   (rd_word)
  );
endmodule

// *** testbench/hspc_top_monitor.sv ***
// Purpose: port-level assertions of the supervision logic
// Assumes: one clock; limits are never raised above reset values
// Notes:   attached to hspc_top by the bind at the foot
`timescale 1ns/100ps
module hspc_chk #(
  parameter TEMP_CYC = 200
) (
  // Clock and reset
  input wire        clk,
  input wire        rst_n,
  // Watched pins
  input wire        vref_low_n,
  input wire        enable_undervolt_pin,
  input wire        overvolt_pin,
  input wire        fault_timeout,
  input wire [15:0] temp_adc,
  input wire        diode_hi_q,
  input wire        gate_on_q,
  input wire        smba_oe_n,
  input wire        sda_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg [31:0] per_q;
  reg [7:0]  wid_q;
  reg        seen_q;
  // Pulse spacing and width counters, restarted by any reset
  always @(posedge clk) begin
    if (!rst_n || !vref_low_n) begin
      per_q  <= 32'h0;
      wid_q  <= 8'h0;
      seen_q <= 1'b0;
    end else begin
      per_q  <= $rose(diode_hi_q) ? 32'h1 : per_q + 32'h1;
      wid_q  <= diode_hi_q ? wid_q + 8'h1 : 8'h0;
      seen_q <= seen_q | $rose(diode_hi_q);
    end
  end
  property p_period;
    $rose(diode_hi_q) && seen_q |-> per_q == TEMP_CYC;
  endproperty
  a_period: assert property (p_period) else $error("diode pulse spacing wrong");
  property p_width;
    $fell(diode_hi_q) && vref_low_n |-> wid_q == 8'd51;
  endproperty
  a_width: assert property (p_width) else $error("diode pulse width wrong");
  property p_uv_off;
    (!enable_undervolt_pin) [*4] |-> !gate_on_q;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("gate on with enable low");
  property p_ov_off;
    overvolt_pin [*4] |-> !gate_on_q;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("gate on in overvoltage");
  property p_gate_rise;
    $rose(gate_on_q) |-> enable_undervolt_pin && !overvolt_pin;
  endproperty
  a_gate_rise: assert property (p_gate_rise) else $error("gate rose while pins forbid");
  property p_ot_fault;
    $fell(diode_hi_q) && vref_low_n && temp_adc > 16'd150 |-> ##[1:6] !gate_on_q;
  endproperty
  a_ot_fault: assert property (p_ot_fault) else $error("hot sample left gate on");
  property p_ot_warn;
    $fell(diode_hi_q) && vref_low_n && temp_adc > 16'd125 |-> ##[1:6] !smba_oe_n;
  endproperty
  a_ot_warn: assert property (p_ot_warn) else $error("warm sample gave no alert");
  property p_timeout;
    $rose(fault_timeout) |-> ##[1:6] !gate_on_q;
  endproperty
  a_timeout: assert property (p_timeout) else $error("fault timeout left gate on");
  property p_ref_rst;
    (!vref_low_n) [*5] |-> !gate_on_q && smba_oe_n && sda_oe_n;
  endproperty
  a_ref_rst: assert property (p_ref_rst) else $error("outputs active in reference reset");
endmodule

bind hspc_top hspc_chk #(.TEMP_CYC(TEMP_CYC)) u_chk (
  .clk(clk), .rst_n(rst_n), .vref_low_n(vref_low_n),
  .enable_undervolt_pin(enable_undervolt_pin), .overvolt_pin(overvolt_pin),
  .fault_timeout(fault_timeout), .temp_adc(temp_adc), .diode_hi_q(diode_hi_q),
  .gate_on_q(gate_on_q), .smba_oe_n(smba_oe_n), .sda_oe_n(sda_oe_n));

// *** testbench/hspc_host_model.sv ***
// Purpose: management host model, bit-level bus master
// Assumes: open-drain lines with pull-up, half phase >= 4 clk
// Notes:   half sets bus speed; read words are shown on rd_vld
`timescale 1ns/100ps
module hspc_host_model (
  // Clock
  input  wire        clk,
  // Bus lines, 1 releases the line
  output reg         scl_o,
  output reg         sda_o,
  input  wire        sda_in,
  // Read result
  output reg         rd_vld,
  output reg  [15:0] rd_data
);
  integer   half;
  reg       rb;
  reg [7:0] rd_byte;
  // Idle bus at time zero
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    rd_vld = 1'b0;
    rd_data = 16'h0000;
    half = 5;
  end
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Start or repeated start
  task start_c;
    begin
      sda_o <= 1'b1;
      tick(half);
      scl_o <= 1'b1;
      tick(half);
      sda_o <= 1'b0;
      tick(half);
      scl_o <= 1'b0;
      tick(half);
    end
  endtask
  task stop_c;
    begin
      sda_o <= 1'b0;
      tick(half);
      scl_o <= 1'b1;
      tick(half);
      sda_o <= 1'b1;
      tick(4 * half);
    end
  endtask
  // One bit: data set in low phase, line sampled in high phase
  task bx(input b);
    begin
      sda_o <= b;
      tick(half);
      scl_o <= 1'b1;
      tick(half);
      rb = sda_in;
      tick(half);
      scl_o <= 1'b0;
      tick(half);
    end
  endtask
  task wb(input [7:0] b);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bx(b[i]);
      bx(1'b1);
    end
  endtask
  task rbyte(input last);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bx(1'b1);
        rd_byte[i] = rb;
      end
      bx(last);
    end
  endtask
  // Write: low byte first, high byte only for words
  task wr(input [6:0] a, input [7:0] c, input [15:0] d, input integer nb);
    begin
      start_c;
      wb({a, 1'b0});
      wb(c);
      wb(d[7:0]);
      if (nb > 1)
        wb(d[15:8]);
      stop_c;
    end
  endtask
  // Word read with repeated start, last byte not acknowledged
  task rd(input [6:0] a, input [7:0] c);
    reg [7:0] lo;
    begin
      start_c;
      wb({a, 1'b0});
      wb(c);
      start_c;
      wb({a, 1'b1});
      rbyte(1'b0);
      lo = rd_byte;
      rbyte(1'b1);
      rd_data <= {rd_byte, lo};
      rd_vld <= 1'b1;
      tick(1);
      rd_vld <= 1'b0;
      stop_c;
    end
  endtask
endmodule

// *** testbench/test_hot_swap_protect_control.sv ***
// Purpose: self-checking bench of the hot-swap supervision logic
// Assumes: host model drives the bus, bench drives the comparators
// Notes:   read words are queued by the driver and checked on arrival
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin \
  error_cnt = error_cnt + 1; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_hot_swap_protect_control;
  reg         clk, rst_n, vref_low_n, vref_above, supply_above;
  reg         en_pin, ov_pin, sns, glow, ftmo;
  reg  [1:0]  a0, a1, a2;
  reg  [15:0] tadc, lim, e_r;
  reg  [6:0]  adr;
  wire        scl, sda_h, sda_oe_n, smba_oe_n, diode_hi, gate_on, rd_vld;
  wire        sda_zero, alert_zero;
  wire [15:0] rd_data;
  integer     error_cnt, cmp_count, k;
  reg  [15:0] exp_q[$];
  // Data line: pull-up, low if either side pulls
  wire        sda = sda_h & sda_oe_n;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  hspc_top #(.TEMP_CYC(200)) DUT (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_zero),
    .sda_oe_n(sda_oe_n), .smba_out(alert_zero), .smba_oe_n(smba_oe_n),
    .vref_low_n(vref_low_n), .vref_above(vref_above),
    .supply_above(supply_above), .address_select_0(a0), .address_select_1(a1),
    .address_select_2(a2), .enable_undervolt_pin(en_pin), .overvolt_pin(ov_pin),
    .sense_over_4mv(sns), .gate_is_low(glow), .fault_timeout(ftmo), .temp_adc(tadc),
    .diode_hi_q(diode_hi), .gate_on_q(gate_on));
  hspc_host_model host (.clk(clk), .scl_o(scl), .sda_o(sda_h), .sda_in(sda),
    .rd_vld(rd_vld), .rd_data(rd_data));
  task final_report;
    begin
      $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Bounded wait for gate (0), alert (1) or diode pulse (2) to reach v
  task wait_for(input integer w, input v, input integer n);
    reg s;
    begin
      s = ~v;
      while (n > 0 && s !== v) begin
        @(negedge clk);
        s = (w == 0) ? gate_on : (w == 1) ? smba_oe_n : diode_hi;
        n = n - 1;
      end
      `CHK(s, v)
      if (s !== v)
        final_report;
    end
  endtask
  // New converter value, changed mid-pulse so the sample is clean
  task set_temp(input [15:0] v);
    begin
      wait_for(2, 1'b1, 400);
      @(posedge clk) tadc <= v;
      wait_for(2, 1'b0, 100);
      repeat (8) @(posedge clk);
    end
  endtask
  task rd_chk(input [6:0] a, input [7:0] c, input [15:0] e);
    begin
      exp_q.push_back(e);
      host.rd(a, c);
    end
  endtask
  // Oldest expected word against each returned word
  always @(posedge clk)
    if (rd_vld) begin
      e_r = exp_q.pop_front();
      `CHK(rd_data, e_r)
    end
  initial begin
    void'($urandom(20786));
    a0 = 2'($urandom % 3);
    a1 = 2'($urandom % 3);
    a2 = 2'($urandom % 3);
    adr = 7'(8'h40 + 9 * a2 + 3 * a1 + a0);
    {rst_n, ov_pin, sns, glow, ftmo} = 5'h00;
    {vref_low_n, vref_above, supply_above, en_pin} = 4'hF;
    tadc = 16'h0019;
    error_cnt = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge clk);
    rd_chk(adr, 8'h03, 16'h0080);
    rd_chk(adr, 8'h4F, 16'h0096);
    rd_chk(adr, 8'h51, 16'h007D);
    rd_chk(adr, 8'hD8, 16'h0000);
    rd_chk(adr ^ 7'h01, 8'h51, 16'hFFFF);
    wait_for(0, 1'b1, 20);
    host.wr(adr, 8'h03, 16'h0000, 1);
    wait_for(0, 1'b0, 20);
    host.wr(adr, 8'h03, 16'h0080, 1);
    wait_for(0, 1'b1, 20);
    `CHK({sda_zero, alert_zero}, 2'b00)
    $display("Test 1 done: operation control");
    set_temp(16'd126);
    wait_for(1, 1'b0, 20);
    wait_for(0, 1'b1, 1);
    rd_chk(adr, 8'h8D, 16'd126);
    set_temp(16'd151);
    wait_for(0, 1'b0, 20);
    set_temp(16'd30);
    wait_for(1, 1'b0, 1);
    host.wr(adr, 8'h04, 16'h0000, 1);
    host.wr(adr, 8'h03, 16'h0000, 1);
    host.wr(adr, 8'h03, 16'h0080, 1);
    wait_for(0, 1'b1, 20);
    wait_for(1, 1'b1, 1);
    $display("Test 2 done: default temperature limits");
    host.half = 12;
    lim = 16'd40 + 16'($urandom % 60);
    host.wr(adr, 8'h51, lim, 2);
    rd_chk(adr, 8'h51, lim);
    set_temp(lim);
    wait_for(1, 1'b1, 1);
    set_temp(lim + 16'd1);
    wait_for(1, 1'b0, 20);
    host.wr(adr, 8'h4F, lim + 16'd10, 2);
    set_temp(lim + 16'd11);
    wait_for(0, 1'b0, 20);
    set_temp(16'd30);
    host.wr(adr, 8'h4F, 16'h0096, 2);
    host.wr(adr, 8'h51, 16'h007D, 2);
    host.wr(adr, 8'h04, 16'h0000, 1);
    wait_for(0, 1'b1, 20);
    host.half = 5;
    $display("Test 3 done: programmed limits");
    @(posedge clk) glow <= 1'b1;
    sns <= 1'b1;
    wait_for(1, 1'b0, 20);
    rd_chk(adr, 8'h80, 16'h0080);
    rd_chk(adr, 8'hE1, 16'h0041);
    @(posedge clk) sns <= 1'b0;
    host.wr(adr, 8'hD8, 16'h0001, 2);
    host.wr(adr, 8'h04, 16'h0000, 1);
    wait_for(1, 1'b1, 20);
    @(posedge clk) sns <= 1'b1;
    repeat (10) @(posedge clk);
    wait_for(1, 1'b1, 1);
    rd_chk(adr, 8'h80, 16'h0080);
    @(posedge clk) sns <= 1'b0;
    glow <= 1'b0;
    host.wr(adr, 8'hD8, 16'h0000, 2);
    $display("Test 4 done: shorted switch");
    @(posedge clk) en_pin <= 1'b0;
    wait_for(0, 1'b0, 10);
    @(posedge clk) en_pin <= 1'b1;
    wait_for(0, 1'b1, 10);
    @(posedge clk) ov_pin <= 1'b1;
    wait_for(0, 1'b0, 10);
    repeat (4) @(posedge clk);
    ov_pin <= 1'b0;
    wait_for(0, 1'b1, 10);
    rd_chk(adr, 8'h51, 16'h007D);
    rd_chk(adr, 8'h03, 16'h0080);
    $display("Test 5 done: enable and overvoltage pins");
    host.wr(adr, 8'h04, 16'h0000, 1);
    host.wr(adr, 8'hD9, 16'h0001, 1);
    for (k = 0; k < 2; k = k + 1) begin
      @(posedge clk) ftmo <= 1'b1;
      wait_for(0, 1'b0, 10);
      @(posedge clk) ftmo <= 1'b0;
      wait_for(0, k == 0, 1100);
    end
    repeat (1200) @(posedge clk);
    wait_for(0, 1'b0, 1);
    rd_chk(adr, 8'hE1, 16'h0002);
    @(posedge clk) en_pin <= 1'b0;
    repeat (5) @(posedge clk);
    en_pin <= 1'b1;
    wait_for(0, 1'b1, 20);
    $display("Test 6 done: retry and latch-off");
    host.wr(adr, 8'h51, 16'h0050, 2);
    @(posedge clk) vref_low_n <= 1'b0;
    vref_above <= 1'b0;
    wait_for(0, 1'b0, 10);
    wait_for(1, 1'b1, 1);
    @(posedge clk) vref_low_n <= 1'b1;
    repeat (30) @(posedge clk);
    rd_chk(adr, 8'h51, 16'hFFFF);
    @(posedge clk) vref_above <= 1'b1;
    repeat (30) @(posedge clk);
    rd_chk(adr, 8'h51, 16'h007D);
    wait_for(0, 1'b1, 20);
    $display("Test 7 done: reference reset");
    final_report;
  end
endmodule
